// ==== io_pin_config_and_routing_matrix_tb.sv ====
`timescale 1ns/1ps
module io_pin_config_and_routing_matrix_tb;
import iopcrm_pkg::*;
logic mclk = 1'b0;
logic srst = 1'b1;
logic [6:0] avs_address = '0;
logic avs_read = 1'b0;
logic avs_write = 1'b0;
logic [31:0] avs_writedata = '0;
logic [31:0] avs_readdata;
logic avs_waitrequest;
logic [63:0] macro_src0, macro_src1;
logic [94:0] macro_in0, macro_in1;
logic [17:0] pad_i, pad_o, pad_oe;
iopcrm_pin_en_t pin_en;
logic ext_reset_o;
logic load = 1'b0;
logic [127:0] pattern = '0;
logic [127:0] pat;
logic [17:0] ext_lvl = '0;
logic [2047:0] shadow = '0;
logic [31:0] exp_q[$], msk_q[$];
logic [31:0] rnd = 32'h27;
logic [21:0] r;
int obs_kind = 0, obs_idx = 0, obs_seq = 0, seen = 0;
int error_cnt = 0, check_count = 0;
int pins[5] = '{0, 1, 8, 2, 9};
int kinds[5] = '{0, 1, 2, 3, 3};
int nmode[5] = '{4, 16, 16, 8, 8};
int k, sel;

always #10 mclk = ~mclk;

iopcrm_top u_iopcrm_top (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .macro_src0(macro_src0), .macro_src1(macro_src1),
	.macro_in0(macro_in0), .macro_in1(macro_in1), .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe),
	.pin_en(pin_en), .ext_reset_o(ext_reset_o));
iopcrm_cells u_iopcrm_cells (.mclk(mclk), .load(load), .pattern(pattern), .ext_lvl(ext_lvl), .pad_o(pad_o),
	.pad_oe(pad_oe), .macro_src0(macro_src0), .macro_src1(macro_src1), .pad_i(pad_i));
////////////////////////////////////////////////////////////////
function automatic logic [31:0] lfsr(input logic [31:0] x);
	return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction

// returns {mask, expected} over the buffer and driver enables
function automatic logic [21:0] en_exp(input int kind, input logic [3:0] md);
	logic [10:0] e;
	logic [10:0] m;
	m = 11'h7FF;
	e = 11'h400 >> md[1:0];
	if (kind == 0 && md[1:0] == 2'h3) e = 11'h000;
	if (kind == 3) begin
		case (md[2:0])
			3'h4: e = 11'h010;
			3'h5: e = 11'h002;
			3'h6: e = 11'h001;
			3'h7: e = 11'h082;
			default: e = 11'h400 >> md[1:0];
		endcase
		// input buffers in drive modes are left open
		if (md[2]) m = 11'h0FF;
	end else if (kind != 0) begin
		case (md[3:2])
			2'h0: e |= 11'h040;
			2'h1: e |= 11'h060;
			2'h2: e |= 11'h008;
			default: e |= 11'h00C;
		endcase
		if (kind == 2 && md[3]) e |= 11'h002;
	end
	return {m, e};
endfunction

task automatic close_out();
	$display("checks %0d errors %0d", check_count, error_cnt);
	if (error_cnt == 0 && check_count > 0) begin
		$display("All checks passed");
	end else begin
		$display("Checks failed");
	end
	$finish;
endtask

task automatic note_exp(input logic [31:0] e, input logic [31:0] m);
	exp_q.push_back(e);
	msk_q.push_back(m);
endtask

task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
	@(posedge mclk);
	avs_address <= a;
	avs_write <= wr;
	avs_read <= ~wr;
	avs_writedata <= d;
	// no cycle count assumed here; a stuck slave is caught by the watchdog
	do begin
		@(posedge mclk);
	end while (avs_waitrequest !== 1'b0);
	avs_write <= 1'b0;
	avs_read <= 1'b0;
endtask

task automatic rd(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m);
	note_exp(e, m);
	bus(1'b0, a, 32'h0);
endtask

task automatic obs(input int kd, input int i, input logic [31:0] e, input logic [31:0] m);
	note_exp(e, m);
	@(posedge mclk);
	obs_kind <= kd;
	obs_idx <= i;
	obs_seq <= obs_seq + 1;
	@(posedge mclk);
endtask

// edits the shadow image and writes every word the field touches
task automatic setf(input int pos, input int w, input logic [31:0] v);
	for (int b = 0; b < w; b++) shadow[pos + b] = v[b];
	bus(1'b1, 7'(pos / 32), shadow[(pos / 32) * 32 +: 32]);
	if ((pos + w - 1) / 32 != pos / 32) bus(1'b1, 7'((pos + w - 1) / 32), shadow[((pos + w - 1) / 32) * 32 +: 32]);
endtask
////////////////////////////////////////////////////////////////
always @(posedge mclk) begin
	logic [31:0] got;
	logic [31:0] e;
	logic [31:0] m;
	logic hit;
	hit = 1'b1;
	got = '0;
	if (avs_read === 1'b1 && avs_waitrequest === 1'b0) got = avs_readdata;
	else if (obs_seq != seen) begin
		seen = obs_seq;
		case (obs_kind)
			0: got = 32'(macro_in0[obs_idx]);
			1: got = 32'(macro_in1[obs_idx]);
			2: got = 32'(pin_en[obs_idx][16:6]);
			3: got = 32'(pin_en[obs_idx][2:0]);
			4: got = {30'h0, pad_o[obs_idx], pad_oe[obs_idx]};
			default: got = 32'(ext_reset_o);
		endcase
	end else hit = 1'b0;
	if (hit) begin
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		check_count++;
		if ((got & m) !== (e & m)) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h kind %0d", $time, got, e, obs_kind);
		end
	end
end

initial begin
	repeat (20000) @(posedge mclk);
	error_cnt++;
	$display("Error %0t: timeout", $time);
	close_out();
end
////////////////////////////////////////////////////////////////
initial begin
	repeat (12) @(posedge mclk);
	srst <= 1'b0;
	rd(7'h3F, 32'h0, '1);
	rd(7'h50, 32'h0, '1);
	bus(1'b1, 7'h50, 32'hFFFFFFFF);
	rd(7'h50, 32'h0, '1);
	rnd = lfsr(rnd);
	bus(1'b1, 7'h3F, rnd);
	rd(7'h3F, rnd, '1);
	for (int p = 0; p < 5; p++) begin
		for (int md = 0; md < nmode[p]; md++) begin
			rnd = lfsr(rnd);
			setf(1140 + 8 * pins[p], 7, {rnd[2:0], md[3:0]});
			r = en_exp(kinds[p], md[3:0]);
			obs(2, pins[p], r[10:0], r[21:11]);
			obs(3, pins[p], {rnd[2] & (p != 0), rnd[1:0]}, 32'h7);
			obs(4, pins[p], {kinds[p] == 3 && md == 6, kinds[p] == 3 && md inside {4, 5, 7}},
				{1'b1, !(kinds[p] == 3 && md == 3)});
		end
	end
	// routing stays inside one matrix except where cross lines are the subject
	for (int i = 0; i < 4; i++) begin
		rnd = lfsr(rnd);
		pat[i * 32 +: 32] = rnd;
	end
	@(posedge mclk);
	pattern <= pat;
	load <= 1'b1;
	@(posedge mclk);
	load <= 1'b0;
	for (int t = 0; t < 10; t++) begin
		rnd = lfsr(rnd);
		k = rnd[7:0] % 95;
		sel = 1 + rnd[15:8] % 23;
		setf(t[0] * 570 + 6 * k, 6, sel);
		obs(t[0], k, pat[t[0] * 64 + sel], 1);
	end
	for (int c = 0; c < 4; c++) begin
		bus(1'b1, 7'h40, {30'h0, c == 2, 1'b0});
		setf(6 * 7, 6, c == 0 ? 0 : (c == 1 ? 63 : 62));
		obs(0, 7, c == 1 || c == 2, 1);
	end
	for (int d = 0; d < 2; d++) begin
		setf(d * 570 + 6 * (85 + 9 * d), 6, 63);
		setf((1 - d) * 570 + 12, 6, 52 + 9 * d);
		obs(1 - d, 2, 1, 1);
		setf(d * 570 + 6 * (85 + 9 * d), 6, 0);
		obs(1 - d, 2, 0, 1);
	end
	// matrix pin driven high with its enable from two matrix outputs
	setf(1148, 7, 0);
	setf(6 * 56, 6, 63);
	setf(6 * 57, 6, 63);
	obs(4, 1, 32'h3, 32'h3);
	setf(1140, 7, 0);
	setf(1140 + 72, 7, 0);
	ext_lvl <= 18'h00201;
	repeat (6) @(posedge mclk);
	setf(24, 6, 24);
	obs(0, 4, 1, 1);
	setf(570 + 24, 6, 24);
	obs(1, 4, 1, 1);
	rd(7'h41, 32'h201, 32'h201);
	bus(1'b1, 7'h40, 32'h4);
	obs(5, 0, 1, 1);
	ext_lvl <= 18'h0;
	repeat (6) @(posedge mclk);
	obs(5, 0, 0, 1);
	bus(1'b1, 7'h3F, rnd);
	bus(1'b1, 7'h40, 32'h1);
	bus(1'b1, 7'h3F, ~rnd);
	rd(7'h3F, rnd, '1);
	rd(7'h40, 32'h1, 32'h1);
	// a fresh reset must clear the lock and the whole store
	srst <= 1'b1;
	@(posedge mclk);
	srst <= 1'b0;
	rd(7'h40, 32'h0, 32'h7);
	rd(7'h3F, 32'h0, '1);
	close_out();
end
endmodule

// ==== iopcrm_cells.sv ====
`timescale 1ns/1ps
module iopcrm_cells (
	input wire logic mclk,
	input wire logic load,
	input wire logic [127:0] pattern,
	input wire logic [17:0] ext_lvl,
	input wire logic [17:0] pad_o,
	input wire logic [17:0] pad_oe,
	output logic [63:0] macro_src0,
	output logic [63:0] macro_src1,
	output logic [17:0] pad_i
);
////////////////////////////////////////////////////////////////
// macrocell outputs only move on request, so routed values hold while sampled
initial begin
	macro_src0 = '0;
	macro_src1 = '0;
end
always @(posedge mclk) begin
	if (load) begin
		macro_src0 <= pattern[63:0];
		macro_src1 <= pattern[127:64];
	end
end
////////////////////////////////////////////////////////////////
// board wire: a driving pin wins, otherwise the board level
assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_lvl);
endmodule

// ==== iopcrm_params.svh ====
// Contract
// - The input-only pin is a digital input or reset source and never drives out.
// - Every pin offers a pull resistor of 10 kOhm, 100 kOhm or 1 MOhm.
// - Input-only pin always pulls down; other pins choose pull-up or pull-down.
// - Input-only mode 00 plain, 01 Schmitt, 10 low voltage, OE low; 11 reserved.
// - Matrix pin input mode 00 plain, 01 Schmitt, 10 low voltage, 11 analog.
// - Matrix pin output 00 single push-pull, 01 double, 10 single drain, 11 double drain.
// - Matrix pins take data and OE from matrix outputs; input feeds a matrix input.
// - Quad-drive pin output modes 10 and 11 also assert the NMOS drain enable.
// - Register pin modes 000-010 select digital inputs with OE low; 011 analog.
// - Register pin 100 push-pull, 101 NMOS drain, 110 PMOS drain, all OE high.
// - Register pin mode 111 asserts NMOS drain and analog enables together.
// - Register and input-only pins derive OE from mode code only.
// - Two matrices, each with 64 source inputs and 95 selectable outputs.
// - Each matrix output is a 64-to-1 selector driven by its own 6-bit code.
// - Each matrix has 10 cross outputs feeding source inputs of the other matrix.
// - 2048 configuration bits are loaded from one-time-programmable storage; the code takes them as bus writes, frozen by the lock until reset.
// - First matrix code 0 is low; 1-13 tables; 14-15 first flip-flops.
// - First matrix 16-19 flip-flops, 20-23 delays and inverter, 24-29 pin inputs; the code feeds its nine pins into 24-32.
// - First matrix 52-61 cross lines from other matrix, 62 reset line, 63 high.
`ifndef IOPCRM_PARAMS_SVH
`define IOPCRM_PARAMS_SVH
`define IOPCRM_NPIN 18
`define IOPCRM_NSRC 64
`define IOPCRM_NOUT 95
`define IOPCRM_SELW 6
`define IOPCRM_NXC 10
`define IOPCRM_SELBITS 570
`define IOPCRM_CFG_BITS 2048
`define IOPCRM_CFG_WORDS 64
`define IOPCRM_M0_BASE 0
`define IOPCRM_M1_BASE 570
`define IOPCRM_PIN_BASE 1140
`define IOPCRM_PIN_STRIDE 8
`define IOPCRM_M0_PINS 9
`define IOPCRM_XC_OUT_FIRST 85
`define IOPCRM_XC_SRC_FIRST 52
`define IOPCRM_SRC_PIN_FIRST 24
`define IOPCRM_SRC_LOW 0
`define IOPCRM_SRC_RESET 62
`define IOPCRM_SRC_HIGH 63
`define IOPCRM_ADDR_CTRL 7'h40
`define IOPCRM_ADDR_STAT_IN 7'h41
`define IOPCRM_ADDR_STAT_OE 7'h42
`define IOPCRM_CTRL_LOCK 0
`define IOPCRM_CTRL_RELEASE 1
`define IOPCRM_CTRL_EXTRST 2
`define IOPCRM_IN_PLAIN 2'h0
`define IOPCRM_IN_SCHMITT 2'h1
`define IOPCRM_IN_LOWV 2'h2
`define IOPCRM_OUT_PP1 2'h0
`define IOPCRM_OUT_PP2 2'h1
`define IOPCRM_OUT_OD1 2'h2
`define IOPCRM_RM_PLAIN 3'h0
`define IOPCRM_RM_SCHMITT 3'h1
`define IOPCRM_RM_LOWV 3'h2
`define IOPCRM_RM_ANALOG 3'h3
`define IOPCRM_RM_PP 3'h4
`define IOPCRM_RM_NOD 3'h5
`define IOPCRM_RM_POD 3'h6
`define IOPCRM_PULL_NONE 2'h0
`endif

// ==== iopcrm_pin_sync.sv ====
`timescale 1ns/1ps
`include "iopcrm_params.svh"
module iopcrm_pin_sync (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [17:0] pad_i,
	output logic [17:0] lvl
);
	import iopcrm_pkg::*;
	iopcrm_sync_s st_q;
	iopcrm_sync_s st_d;
	always_comb begin
		st_d = st_q;
		st_d.s1 = pad_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// a level is taken only once two late stages agree, filtering one-cycle glitches
		for (int i = 0; i < `IOPCRM_NPIN; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.lvl[i] = st_q.s3[i];
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign lvl = st_q.lvl;
endmodule

// ==== iopcrm_pkg.sv ====
package iopcrm_pkg;
	typedef enum {kind_input_only_pin, kind_matrix, kind_matrix_quad, kind_register} iopcrm_kind_e;
	typedef struct packed {
		logic plain_input_buffer_en;
		logic schmitt_input_en;
		logic low_voltage_input_en;
		logic analog_io_en;
		logic pushpull_single_en;
		logic pushpull_double_en;
		logic pushpull_drive_en;
		logic opendrain_single_en;
		logic opendrain_double_en;
		logic nmos_opendrain_en;
		logic pmos_opendrain_en;
		logic oe_from_mode;
		logic oe_mode_level;
		logic pull_en;
		logic pull_up;
		logic [1:0] pull_sel;
	} iopcrm_pin_en_s;
	typedef iopcrm_pin_en_s [17:0] iopcrm_pin_en_t;
	typedef struct packed {
		logic [2047:0] cfg;
		logic lock;
		logic release_n;
		logic ext_reset_en;
		logic ack;
		logic [31:0] rdata;
	} iopcrm_state_s;
	typedef struct packed {
		logic [17:0] s1;
		logic [17:0] s2;
		logic [17:0] s3;
		logic [17:0] lvl;
	} iopcrm_sync_s;
endpackage

// ==== iopcrm_route_mux.sv ====
`timescale 1ns/1ps
`include "iopcrm_params.svh"
module iopcrm_route_mux (
	input wire logic [63:0] src,
	input wire logic [569:0] sel_flat,
	output logic [94:0] dst
);
	import iopcrm_pkg::*;
	// one selector per macrocell input, no storage in the path
	always_comb begin
		for (int k = 0; k < `IOPCRM_NOUT; k++) begin
			dst[k] = src[sel_flat[k*`IOPCRM_SELW +: `IOPCRM_SELW]];
		end
	end
endmodule

// ==== iopcrm_top.sv ====
`timescale 1ns/1ps
`include "iopcrm_params.svh"
module iopcrm_top (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [63:0] macro_src0,
	input wire logic [63:0] macro_src1,
	output logic [94:0] macro_in0,
	output logic [94:0] macro_in1,
	input wire logic [17:0] pad_i,
	output logic [17:0] pad_o,
	output logic [17:0] pad_oe,
	output iopcrm_pkg::iopcrm_pin_en_t pin_en,
	output logic ext_reset_o
);
	import iopcrm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin tables

	function automatic iopcrm_kind_e pin_kind(input int p);
		case (p)
			0: pin_kind = kind_input_only_pin;
			8: pin_kind = kind_matrix_quad;
			2, 4, 6, 9, 12, 14, 17: pin_kind = kind_register;
			default: pin_kind = kind_matrix;
		endcase
	endfunction

	// matrix output number that carries a pin's digital out
	function automatic int pin_data_idx(input int p);
		case (p)
			1: pin_data_idx = 56;
			2: pin_data_idx = 58;
			3: pin_data_idx = 59;
			4: pin_data_idx = 61;
			5: pin_data_idx = 62;
			6: pin_data_idx = 64;
			7: pin_data_idx = 65;
			8: pin_data_idx = 67;
			9: pin_data_idx = 56;
			10: pin_data_idx = 57;
			11: pin_data_idx = 59;
			12: pin_data_idx = 61;
			13: pin_data_idx = 62;
			14: pin_data_idx = 64;
			15: pin_data_idx = 65;
			16: pin_data_idx = 67;
			17: pin_data_idx = 69;
			default: pin_data_idx = 0;
		endcase
	endfunction

	// the output enable line sits right after the data line
	function automatic int pin_oe_idx(input int p);
		pin_oe_idx = pin_data_idx(p) + 1;
	endfunction

	function automatic iopcrm_pin_en_s decode_pin(input iopcrm_kind_e k, input logic [7:0] c);
		iopcrm_pin_en_s e;
		e = '0;
		e.pull_sel = c[5:4];
		e.pull_en = (c[5:4] != `IOPCRM_PULL_NONE);
		e.pull_up = (k != kind_input_only_pin) & c[6];
		case (k)
			kind_input_only_pin: begin
				e.oe_from_mode = 1'b1;
				e.oe_mode_level = 1'b0;
				case (c[1:0])
					`IOPCRM_IN_PLAIN: e.plain_input_buffer_en = 1'b1;
					`IOPCRM_IN_SCHMITT: e.schmitt_input_en = 1'b1;
					`IOPCRM_IN_LOWV: e.low_voltage_input_en = 1'b1;
					default: e.plain_input_buffer_en = 1'b0;
				endcase
			end
			kind_matrix, kind_matrix_quad: begin
				case (c[1:0])
					`IOPCRM_IN_PLAIN: e.plain_input_buffer_en = 1'b1;
					`IOPCRM_IN_SCHMITT: e.schmitt_input_en = 1'b1;
					`IOPCRM_IN_LOWV: e.low_voltage_input_en = 1'b1;
					default: e.analog_io_en = 1'b1;
				endcase
				case (c[3:2])
					`IOPCRM_OUT_PP1: e.pushpull_single_en = 1'b1;
					`IOPCRM_OUT_PP2: begin
						e.pushpull_single_en = 1'b1;
						e.pushpull_double_en = 1'b1;
					end
					`IOPCRM_OUT_OD1: begin
						e.opendrain_single_en = 1'b1;
						e.nmos_opendrain_en = (k == kind_matrix_quad);
					end
					default: begin
						e.opendrain_single_en = 1'b1;
						e.opendrain_double_en = 1'b1;
						e.nmos_opendrain_en = (k == kind_matrix_quad);
					end
				endcase
			end
			kind_register: begin
				e.oe_from_mode = 1'b1;
				case (c[2:0])
					`IOPCRM_RM_PLAIN: e.plain_input_buffer_en = 1'b1;
					`IOPCRM_RM_SCHMITT: e.schmitt_input_en = 1'b1;
					`IOPCRM_RM_LOWV: e.low_voltage_input_en = 1'b1;
					`IOPCRM_RM_ANALOG: e.analog_io_en = 1'b1;
					`IOPCRM_RM_PP: begin
						e.pushpull_drive_en = 1'b1;
						e.oe_mode_level = 1'b1;
					end
					`IOPCRM_RM_NOD: begin
						e.nmos_opendrain_en = 1'b1;
						e.oe_mode_level = 1'b1;
					end
					`IOPCRM_RM_POD: begin
						e.pmos_opendrain_en = 1'b1;
						e.oe_mode_level = 1'b1;
					end
					default: begin
						e.nmos_opendrain_en = 1'b1;
						e.analog_io_en = 1'b1;
						e.oe_mode_level = 1'b1;
					end
				endcase
			end
			default: e.oe_from_mode = 1'b1;
		endcase
		decode_pin = e;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// configuration store and bus slave

	iopcrm_state_s st_q;
	iopcrm_state_s st_d;
	logic [17:0] pin_lvl;
	logic [17:0] din;
	logic [63:0] src0;
	logic [63:0] src1;
	logic bus_req;
	logic bus_accept;
	int waddr;

	assign bus_req = avs_read | avs_write;
	// one wait state: the request is answered on its second edge
	assign avs_waitrequest = bus_req & ~st_q.ack;
	assign bus_accept = bus_req & st_q.ack;
	assign waddr = int'(avs_address[5:0]);

	always_comb begin
		st_d = st_q;
		st_d.ack = bus_req & ~st_q.ack;
		if (bus_req & ~st_q.ack) begin
			st_d.rdata = 32'h0;
			if (!avs_address[6]) begin
				st_d.rdata = st_q.cfg[waddr*32 +: 32];
			end else if (avs_address == `IOPCRM_ADDR_CTRL) begin
				st_d.rdata[`IOPCRM_CTRL_LOCK] = st_q.lock;
				st_d.rdata[`IOPCRM_CTRL_RELEASE] = st_q.release_n;
				st_d.rdata[`IOPCRM_CTRL_EXTRST] = st_q.ext_reset_en;
			end else if (avs_address == `IOPCRM_ADDR_STAT_IN) begin
				st_d.rdata[17:0] = din;
			end else if (avs_address == `IOPCRM_ADDR_STAT_OE) begin
				st_d.rdata[17:0] = pad_oe;
			end
		end
		if (bus_accept & avs_write) begin
			// once locked the store behaves as one-time memory until reset
			if (!avs_address[6] && !st_q.lock) begin
				for (int b = 0; b < 4; b++) begin
					if (avs_byteenable[b]) begin
						st_d.cfg[waddr*32 + b*8 +: 8] = avs_writedata[b*8 +: 8];
					end
				end
			end else if (avs_address == `IOPCRM_ADDR_CTRL && avs_byteenable[0]) begin
				st_d.lock = st_q.lock | avs_writedata[`IOPCRM_CTRL_LOCK];
				st_d.release_n = avs_writedata[`IOPCRM_CTRL_RELEASE];
				st_d.ext_reset_en = avs_writedata[`IOPCRM_CTRL_EXTRST];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign avs_readdata = st_q.rdata;

	////////////////////////////////////////////////////////////////////////////////
	// pin inputs and matrices

	iopcrm_pin_sync u_sync (
		.mclk(mclk),
		.srst(srst),
		.pad_i(pad_i),
		.lvl(pin_lvl)
	);

	always_comb begin
		din = '0;
		for (int p = 0; p < `IOPCRM_NPIN; p++) begin
			// analog-only pins feed low into the matrix
			din[p] = pin_lvl[p] & (pin_en[p].plain_input_buffer_en | pin_en[p].schmitt_input_en |
				pin_en[p].low_voltage_input_en);
		end
	end

	// cross lines join the matrices; a loop through both is possible by configuration
	always_comb begin
		src0 = macro_src0;
		src1 = macro_src1;
		src0[`IOPCRM_SRC_LOW] = 1'b0;
		src1[`IOPCRM_SRC_LOW] = 1'b0;
		src0[45] = 1'b0;
		src0[46] = 1'b0;
		src0[47] = 1'b0;
		src0[51] = 1'b0;
		for (int p = 0; p < `IOPCRM_M0_PINS; p++) begin
			src0[`IOPCRM_SRC_PIN_FIRST + p] = din[p];
			src1[`IOPCRM_SRC_PIN_FIRST + p] = din[`IOPCRM_M0_PINS + p];
		end
		for (int x = 0; x < `IOPCRM_NXC; x++) begin
			src0[`IOPCRM_XC_SRC_FIRST + x] = macro_in1[`IOPCRM_XC_OUT_FIRST + x];
			src1[`IOPCRM_XC_SRC_FIRST + x] = macro_in0[`IOPCRM_XC_OUT_FIRST + x];
		end
		src0[`IOPCRM_SRC_RESET] = st_q.release_n;
		src1[`IOPCRM_SRC_RESET] = st_q.release_n;
		src0[`IOPCRM_SRC_HIGH] = 1'b1;
		src1[`IOPCRM_SRC_HIGH] = 1'b1;
	end

	iopcrm_route_mux u_m0 (
		.src(src0),
		.sel_flat(st_q.cfg[`IOPCRM_M0_BASE +: `IOPCRM_SELBITS]),
		.dst(macro_in0)
	);

	iopcrm_route_mux u_m1 (
		.src(src1),
		.sel_flat(st_q.cfg[`IOPCRM_M1_BASE +: `IOPCRM_SELBITS]),
		.dst(macro_in1)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pad drivers

	always_comb begin
		logic data;
		logic oe_src;
		data = 1'b0;
		oe_src = 1'b0;
		pad_o = '0;
		pad_oe = '0;
		for (int p = 0; p < `IOPCRM_NPIN; p++) begin
			pin_en[p] = decode_pin(pin_kind(p), st_q.cfg[`IOPCRM_PIN_BASE + p*`IOPCRM_PIN_STRIDE +: 8]);
			if (p < `IOPCRM_M0_PINS) begin
				data = macro_in0[pin_data_idx(p)];
				oe_src = macro_in0[pin_oe_idx(p)];
			end else begin
				data = macro_in1[pin_data_idx(p)];
				oe_src = macro_in1[pin_oe_idx(p)];
			end
			if (pin_en[p].oe_from_mode) begin
				oe_src = pin_en[p].oe_mode_level;
			end
			if (pin_kind(p) == kind_input_only_pin) begin
				pad_oe[p] = 1'b0;
			end else if (pin_en[p].pushpull_single_en | pin_en[p].pushpull_drive_en) begin
				pad_o[p] = data;
				pad_oe[p] = oe_src;
			end else if (pin_en[p].opendrain_single_en | pin_en[p].nmos_opendrain_en) begin
				pad_oe[p] = oe_src & ~data;
			end else if (pin_en[p].pmos_opendrain_en) begin
				pad_o[p] = 1'b1;
				pad_oe[p] = oe_src & data;
			end
		end
	end

	assign ext_reset_o = st_q.ext_reset_en & din[0];

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	logic [7:0] c0;
	logic [7:0] c1;
	logic [7:0] c2;
	logic [7:0] c8;
	assign c0 = st_q.cfg[`IOPCRM_PIN_BASE +: 8];
	assign c1 = st_q.cfg[`IOPCRM_PIN_BASE + `IOPCRM_PIN_STRIDE +: 8];
	assign c2 = st_q.cfg[`IOPCRM_PIN_BASE + 2*`IOPCRM_PIN_STRIDE +: 8];
	assign c8 = st_q.cfg[`IOPCRM_PIN_BASE + 8*`IOPCRM_PIN_STRIDE +: 8];

	sequence s_req_held;
		bus_req && avs_waitrequest;
	endsequence
	sequence s_answered;
		!avs_waitrequest ##1 !st_q.ack;
	endsequence

	only_input_quiet_a: assert property (!pad_oe[0] && !pin_en[0].pushpull_single_en && !pin_en[0].nmos_opendrain_en)
		else $error("input-only pin drives");
	input_pull_down_a: assert property (!pin_en[0].pull_up && (pin_en[1].pull_up == c1[6]))
		else $error("pull direction wrong");
	pull_value_a: assert property (pin_en[1].pull_en == (c1[5:4] != 2'h0) && pin_en[1].pull_sel == c1[5:4])
		else $error("pull value wrong");
	gpi_mode_a: assert property ((c0[1:0] == 2'h1) |-> (pin_en[0].schmitt_input_en && !pin_en[0].plain_input_buffer_en))
		else $error("input-only mode decode wrong");
	matrix_in_mode_a: assert property ((c1[1:0] == 2'h3) |-> (pin_en[1].analog_io_en && !pin_en[1].low_voltage_input_en))
		else $error("matrix pin input decode wrong");
	matrix_out_mode_a: assert property ((c1[3:2] == 2'h1) |-> (pin_en[1].pushpull_single_en && pin_en[1].pushpull_double_en))
		else $error("matrix pin output decode wrong");
	quad_drain_a: assert property ((c8[3] == 1'b1) |-> (pin_en[8].nmos_opendrain_en && !pin_en[1].nmos_opendrain_en))
		else $error("quad pin drain enable missing");
	reg_input_oe_a: assert property ((c2[2:0] < 3'h3) |-> !pad_oe[2])
		else $error("register pin drives in input mode");
	reg_out_oe_a: assert property ((c2[2:0] == 3'h4) |-> (pad_oe[2] && pad_o[2] == macro_in0[58]))
		else $error("register pin push-pull wrong");
	reg_mixed_a: assert property ((c2[2:0] == 3'h7) |-> (pin_en[2].nmos_opendrain_en && pin_en[2].analog_io_en))
		else $error("mixed mode enables wrong");
	matrix_pin_oe_a: assert property ((c1[3:2] == 2'h0) |-> (pad_oe[1] == macro_in0[57] && pad_o[1] == macro_in0[56]))
		else $error("matrix pin not driven from matrix");
	const_select_a: assert property ((st_q.cfg[47:42] inside {6'h00, 6'h3F}) |-> (macro_in0[7] == st_q.cfg[42]))
		else $error("constant source wrong");
	cross_link_a: assert property ((st_q.cfg[`IOPCRM_M1_BASE + 12 +: 6] == 6'h34) |-> (macro_in1[2] == macro_in0[85]))
		else $error("cross connection broken");
	bus_answer_a: assert property (s_req_held |=> s_answered)
		else $error("bus answer late");
	lock_hold_a: assert property ((st_q.lock && avs_write && !avs_address[6]) |=> $stable(st_q.cfg))
		else $error("locked store changed");
endmodule
